// ===== logic/reset_flush_slew_select_regs.sv
// Reset/flush control and output slew select register bank
//
// Contract
// - Writing 1 to soft reset starts a software reset; bit self-clears.
// - Writing 1 to flush empties the FIFO; bit clears when done.
// - Flush bit reads 0 no later than 1.5 us after the write.
// - On I3C, entering HDR-DDR selects the DDR slew code, bits 5:3.
// - HDR exit pattern returns selection to the SDR code, bits 2:0.
// - After any reset the I2C slew setting drives the data output.
// - With I3C enabled, broadcast write header selects the SDR code.
// - First host write over SPI after reset selects SPI slew setting.
`timescale 1ns/1ps
module reset_flush_slew_select_regs (
  input  wire logic       clk_sys,
  input  wire logic       rstn,
  // Register access from the serial interface decoder
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       wr_is_spi,
  output logic      [7:0] reg_rdata,
  // Protocol events from the link, outside this clock domain
  input  wire logic       i3c_enabled,
  input  wire logic       ev_bcast_write,
  input  wire logic       ev_enter_ddr,
  input  wire logic       ev_hdr_exit,
  // Slew code inputs, drive and control outputs
  input  wire logic [2:0] i2c_slew_code,
  input  wire logic [2:0] spi_slew_code,
  output logic      [2:0] data_out_slew,
  output logic      [1:0] slew_source,
  output logic            slew_reserved,
  output logic            soft_reset_pulse,
  output logic            fifo_flush_req
);
  // ------------------------------------------------------------
  // Reset release
  // ------------------------------------------------------------
  logic rst_meta_n;
  logic rst_sync_n;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rst_meta_n <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_sync_n <= rst_meta_n;
    end
  end

  // ------------------------------------------------------------
  // Link event synchronisation
  // ------------------------------------------------------------
  logic [3:0] ev_level;
  logic [3:0] ev_rise;

  event_sync #(
    .WIDTH(4)
  ) u_event_sync (
    .clk_sys    (clk_sys),
    .rst_sync_n (rst_sync_n),
    .async_in   ({i3c_enabled, ev_hdr_exit, ev_enter_ddr, ev_bcast_write}),
    .level      (ev_level),
    .rise       (ev_rise)
  );

  // ------------------------------------------------------------
  // Register state
  // ------------------------------------------------------------
  logic                    soft_reset_bit;
  logic                    flush_bit;
  logic [7:0]              flush_count;
  logic [7:0]              soft_count;
  logic [5:0]              slew_codes;
  logic                    first_write_seen;
  slew_regs_pkg::slew_src_t src;
  logic                    next_soft_reset_bit;
  logic                    next_flush_bit;
  logic [7:0]              next_flush_count;
  logic [7:0]              next_soft_count;
  logic [5:0]              next_slew_codes;
  logic                    next_first_write_seen;
  slew_regs_pkg::slew_src_t next_src;
  logic [7:0]              next_reg_rdata;
  logic [2:0]              next_data_out_slew;
  logic [1:0]              next_slew_source;
  logic                    next_slew_reserved;

  logic wr_path;
  logic wr_slew;
  assign wr_path = reg_wr && (reg_addr == slew_regs_pkg::PATH_RESET_OFFSET);
  assign wr_slew = reg_wr && (reg_addr == slew_regs_pkg::SLEW_SELECT_OFFSET);

  function automatic logic is_reserved(input logic [2:0] code);
    is_reserved = code[2] & code[1];
  endfunction

  always_comb begin
    next_soft_reset_bit   = soft_reset_bit;
    next_soft_count       = soft_count;
    next_flush_bit        = flush_bit;
    next_flush_count      = flush_count;
    next_slew_codes       = slew_codes;
    next_first_write_seen = first_write_seen;
    next_src              = src;
    // Soft reset: bit held for a fixed count, then cleared by hardware
    if (soft_reset_bit) begin
      if (soft_count == 8'h00) begin
        next_soft_reset_bit = 1'b0;
      end else begin
        next_soft_count = soft_count - 8'h01;
      end
    end else if (wr_path && reg_wdata[slew_regs_pkg::SOFT_RESET_BIT]) begin
      next_soft_reset_bit = 1'b1;
      next_soft_count     = slew_regs_pkg::SOFT_RESET_CYCLES;
    end
    // Flush: written 0 is ignored, a new 1 restarts the count
    if (wr_path && reg_wdata[slew_regs_pkg::FLUSH_BIT]) begin
      next_flush_bit   = 1'b1;
      next_flush_count = slew_regs_pkg::FLUSH_CYCLES;
    end else if (flush_bit) begin
      if (flush_count == 8'h00) begin
        next_flush_bit = 1'b0;
      end else begin
        next_flush_count = flush_count - 8'h01;
      end
    end
    // Slew codes; writes during DDR are the host's fault and still land
    if (wr_slew) begin
      next_slew_codes = reg_wdata[5:0] & slew_regs_pkg::SLEW_SELECT_MASK[5:0];
    end
    // Source selection from protocol events
    if (reg_wr && !first_write_seen) begin
      next_first_write_seen = 1'b1;
      if (wr_is_spi) begin
        next_src = slew_regs_pkg::SRC_SPI;
      end
    end
    if (ev_level[3]) begin
      if (ev_rise[1] && src == slew_regs_pkg::SRC_SDR) begin
        next_src = slew_regs_pkg::SRC_DDR;
      end else if (ev_rise[2] && src == slew_regs_pkg::SRC_DDR) begin
        next_src = slew_regs_pkg::SRC_SDR;
      end else if (ev_rise[0] && src != slew_regs_pkg::SRC_DDR) begin
        next_src = slew_regs_pkg::SRC_SDR;
      end
    end
    // Soft reset returns every setting to its reset state
    if (soft_reset_bit && soft_count == 8'h00) begin
      next_slew_codes       = slew_regs_pkg::SLEW_SELECT_RESET[5:0];
      next_src              = slew_regs_pkg::SRC_I2C;
      next_first_write_seen = 1'b0;
      next_flush_bit        = 1'b0;
    end
  end

  always_comb begin
    next_reg_rdata = 8'h00;
    if (reg_rd && reg_addr == slew_regs_pkg::PATH_RESET_OFFSET) begin
      next_reg_rdata[slew_regs_pkg::SOFT_RESET_BIT] = soft_reset_bit;
      next_reg_rdata[slew_regs_pkg::FLUSH_BIT]      = flush_bit;
    end else if (reg_rd && reg_addr == slew_regs_pkg::SLEW_SELECT_OFFSET) begin
      next_reg_rdata = {2'b00, slew_codes};
    end
    unique case (next_src)
      slew_regs_pkg::SRC_I2C: begin
        next_data_out_slew = i2c_slew_code;
        next_slew_source   = 2'b00;
      end
      slew_regs_pkg::SRC_SPI: begin
        next_data_out_slew = spi_slew_code;
        next_slew_source   = 2'b01;
      end
      slew_regs_pkg::SRC_SDR: begin
        next_data_out_slew = next_slew_codes[2:0];
        next_slew_source   = 2'b10;
      end
      slew_regs_pkg::SRC_DDR: begin
        next_data_out_slew = next_slew_codes[5:3];
        next_slew_source   = 2'b11;
      end
      default: begin
        next_data_out_slew = i2c_slew_code;
        next_slew_source   = 2'b00;
      end
    endcase
    next_slew_reserved = is_reserved(next_data_out_slew);
  end

  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      soft_reset_bit   <= 1'b0;
      soft_count       <= 8'h00;
      flush_bit        <= 1'b0;
      flush_count      <= 8'h00;
      slew_codes       <= slew_regs_pkg::SLEW_SELECT_RESET[5:0];
      first_write_seen <= 1'b0;
      src              <= slew_regs_pkg::SRC_I2C;
      reg_rdata        <= 8'h00;
      data_out_slew    <= 3'h0;
      slew_source      <= 2'b00;
      slew_reserved    <= 1'b0;
      soft_reset_pulse <= 1'b0;
      fifo_flush_req   <= 1'b0;
    end else begin
      soft_reset_bit   <= next_soft_reset_bit;
      soft_count       <= next_soft_count;
      flush_bit        <= next_flush_bit;
      flush_count      <= next_flush_count;
      slew_codes       <= next_slew_codes;
      first_write_seen <= next_first_write_seen;
      src              <= next_src;
      reg_rdata        <= next_reg_rdata;
      data_out_slew    <= next_data_out_slew;
      slew_source      <= next_slew_source;
      slew_reserved    <= next_slew_reserved;
      soft_reset_pulse <= next_soft_reset_bit;
      fifo_flush_req   <= next_flush_bit;
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  logic [7:0] flush_age;
  logic [7:0] next_flush_age;

  always_comb begin
    next_flush_age = flush_bit ? flush_age + 8'h01 : 8'h00;
  end

  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      flush_age <= 8'h00;
    end else begin
      flush_age <= next_flush_age;
    end
  end

  a_flush_bounded: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
    flush_age < 8'(slew_regs_pkg::FLUSH_LIMIT_CYCLES)) else $error("flush bit held too long");
  a_flush_sets: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
    wr_path && reg_wdata[slew_regs_pkg::FLUSH_BIT] |=> flush_bit ##1 fifo_flush_req)
    else $error("flush write not taken");
  a_soft_clears: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
    $rose(soft_reset_bit) |-> ##[1:8] !soft_reset_bit) else $error("soft reset bit stuck");
  a_soft_output: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
    soft_reset_bit |-> soft_reset_pulse) else $error("soft reset output missing");
  a_ddr_select: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
    src == slew_regs_pkg::SRC_DDR |=> slew_source == 2'b11 || $past(src) != src)
    else $error("ddr source not shown");
  a_ddr_code: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
    slew_source == 2'b11 |-> data_out_slew == slew_codes[5:3]) else $error("ddr code wrong");
  a_exit_sdr: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
    src == slew_regs_pkg::SRC_DDR && ev_rise[2] && ev_level[3] && !(soft_reset_bit && soft_count == 8'h00)
    |=> src == slew_regs_pkg::SRC_SDR) else $error("hdr exit ignored");
  a_reset_i2c: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
    $fell(soft_reset_bit) |-> src == slew_regs_pkg::SRC_I2C) else $error("reset not i2c");
  a_spi_first: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
    reg_wr && wr_is_spi && !first_write_seen && !ev_level[3] && !soft_reset_bit
    |=> src == slew_regs_pkg::SRC_SPI) else $error("spi switch missed");
  a_reserved_flag: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
    slew_reserved == is_reserved(data_out_slew)) else $error("reserved flag wrong");
endmodule

// ===== pkg/slew_regs_pkg.sv
// Constants for the reset/flush and output slew select registers
package slew_regs_pkg;
  // ------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------
  localparam logic [7:0] PATH_RESET_OFFSET   = 8'h02;
  localparam logic [7:0] SLEW_SELECT_OFFSET  = 8'h03;
  localparam logic [7:0] PATH_RESET_RESET    = 8'h00;
  localparam logic [7:0] SLEW_SELECT_RESET   = 8'h2B;
  localparam int         SOFT_RESET_BIT      = 4;
  localparam int         FLUSH_BIT           = 2;
  localparam int         DDR_CODE_LSB        = 3;
  localparam int         SDR_CODE_LSB        = 0;
  localparam logic [7:0] SLEW_SELECT_MASK    = 8'h3F;
  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int         CLK_PERIOD_PS       = 25000;
  localparam int         FLUSH_LIMIT_PS      = 1500000;
  localparam int         FLUSH_LIMIT_CYCLES  = FLUSH_LIMIT_PS / CLK_PERIOD_PS;
  localparam logic [7:0] FLUSH_CYCLES        = 8'h04;
  localparam logic [7:0] SOFT_RESET_CYCLES   = 8'h04;
  // ------------------------------------------------------------
  // Output slew source
  // ------------------------------------------------------------
  typedef enum logic [3:0] {
    SRC_I2C = 4'h1,
    SRC_SPI = 4'h2,
    SRC_SDR = 4'h4,
    SRC_DDR = 4'h8
  } slew_src_t;
endpackage

// ===== logic/event_sync.sv
// Three-stage synchroniser with agreement filter for pin-side events
`timescale 1ns/1ps
module event_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_sys,
  input  wire logic             rst_sync_n,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] level,
  output logic      [WIDTH-1:0] rise
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  logic [WIDTH-1:0] next_level;

  always_comb begin
    next_level = level;
    for (int i = 0; i < WIDTH; i++) begin
      if (stage2[i] == stage3[i]) begin
        next_level[i] = stage3[i];
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
      level  <= '0;
    end else begin
      stage1 <= async_in;
      stage2 <= stage1;
      stage3 <= stage2;
      level  <= next_level;
    end
  end

  assign rise = next_level & ~level;
endmodule

// ===== sim/host_link_model.sv
// Host-side link model raising protocol events on a gated link clock
`timescale 1ns/1ps
module host_link_model;
  logic link_clk;
  logic ev_bcast_write;
  logic ev_enter_ddr;
  logic ev_hdr_exit;
  initial begin
    link_clk = 1'b1;
    ev_bcast_write = 1'b0;
    ev_enter_ddr = 1'b0;
    ev_hdr_exit = 1'b0;
  end
  // ------------------------------------------------------------
  // Event frame: link clock runs only inside it, 200 ns period
  // ------------------------------------------------------------
  task automatic fire(input int kind);
    for (int i = 0; i < 4; i++) begin
      #100 link_clk = 1'b0;
      if (i == 0) begin
        ev_bcast_write = (kind == 0);
        ev_enter_ddr = (kind == 1);
        ev_hdr_exit = (kind == 2);
      end
      if (i == 2) begin
        ev_bcast_write = 1'b0;
        ev_enter_ddr = 1'b0;
        ev_hdr_exit = 1'b0;
      end
      #100 link_clk = 1'b1;
    end
  endtask
endmodule

// ===== sim/tb_reset_flush_slew_select_regs.sv
// Self-checking bench for the reset/flush and slew select registers
`timescale 1ns/1ps
module tb_reset_flush_slew_select_regs;
  logic        clk_sys = 1'b0;
  logic        rstn = 1'b0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [7:0]  reg_wdata = 8'h00;
  logic        wr_is_spi = 1'b0;
  logic        i3c_enabled = 1'b0;
  logic [2:0]  i2c_slew_code = 3'h0;
  logic [2:0]  spi_slew_code = 3'h0;
  logic [7:0]  reg_rdata;
  logic [2:0]  data_out_slew;
  logic [1:0]  slew_source;
  logic        slew_reserved;
  logic        soft_reset_pulse;
  logic        fifo_flush_req;
  logic [31:0] seed = 32'h88F5;
  logic [7:0]  rd_val;
  int          bad_count = 0;
  int          n_compared = 0;
  int          cycles = 0;
  int          slew_q = 8'h2B;
  int          src_q = 0;
  int          exp_q[$];
  host_link_model link ();
  reset_flush_slew_select_regs uut (
    .clk_sys(clk_sys), .rstn(rstn), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .wr_is_spi(wr_is_spi),
    .reg_rdata(reg_rdata), .i3c_enabled(i3c_enabled),
    .ev_bcast_write(link.ev_bcast_write), .ev_enter_ddr(link.ev_enter_ddr),
    .ev_hdr_exit(link.ev_hdr_exit), .i2c_slew_code(i2c_slew_code),
    .spi_slew_code(spi_slew_code), .data_out_slew(data_out_slew),
    .slew_source(slew_source), .slew_reserved(slew_reserved),
    .soft_reset_pulse(soft_reset_pulse), .fifo_flush_req(fifo_flush_req)
  );
  always #12.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      end_sim();
    end
  end
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [2:0] exp_slew();
    case (src_q)
      0: return i2c_slew_code;
      1: return spi_slew_code;
      2: return 3'(slew_q & 7);
      default: return 3'((slew_q >> 3) & 7);
    endcase
  endfunction
  task automatic cmp(input string name, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", name, exp, got);
      bad_count++;
    end
  endtask
  task automatic chk_out();
    cmp("slew_source", 8'(src_q), {6'h00, slew_source});
    cmp("data_out_slew", {5'h00, exp_slew()}, {5'h00, data_out_slew});
    cmp("slew_reserved", {7'h00, exp_slew() >= 3'h6}, {7'h00, slew_reserved});
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic spi);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    wr_is_spi <= spi;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    rd_val = reg_rdata;
  endtask
  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clk_sys);
    rstn <= 1'b1;
    i2c_slew_code <= 3'(rnd() % 6);
    spi_slew_code <= 3'(rnd() % 6);
    i3c_enabled <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rd(slew_regs_pkg::PATH_RESET_OFFSET);
    cmp("path_reset", slew_regs_pkg::PATH_RESET_RESET, rd_val);
    rd(slew_regs_pkg::SLEW_SELECT_OFFSET);
    cmp("slew_select", slew_regs_pkg::SLEW_SELECT_RESET, rd_val);
    rd(8'h55);
    cmp("unmapped", 8'h00, rd_val);
    chk_out();
    $display("test reset values done");
    for (int k = 0; k < 6; k++) begin
      slew_q = int'(((rnd() % 6) << 3) | (rnd() % 6));
      exp_q.push_back(slew_q);
      wr(slew_regs_pkg::SLEW_SELECT_OFFSET, 8'(slew_q) | 8'hC0, 1'b0);
      rd(slew_regs_pkg::SLEW_SELECT_OFFSET);
      cmp("slew_select", 8'(exp_q.pop_front()), rd_val);
      link.fire(0);
      src_q = 2;
      chk_out();
      link.fire(1);
      src_q = 3;
      chk_out();
      link.fire(2);
      src_q = 2;
      chk_out();
    end
    slew_q = 8'h36;
    wr(slew_regs_pkg::SLEW_SELECT_OFFSET, 8'h36, 1'b0);
    repeat (3) @(posedge clk_sys);
    #1;
    chk_out();
    $display("test slew events done");
    wr(slew_regs_pkg::PATH_RESET_OFFSET, 8'h04, 1'b0);
    cmp("fifo_flush_req", 8'h01, {7'h00, fifo_flush_req});
    rd(slew_regs_pkg::PATH_RESET_OFFSET);
    cmp("path_reset", 8'h04, rd_val);
    repeat (slew_regs_pkg::FLUSH_LIMIT_CYCLES) @(posedge clk_sys);
    rd(slew_regs_pkg::PATH_RESET_OFFSET);
    cmp("path_reset", 8'h00, rd_val);
    cmp("fifo_flush_req", 8'h00, {7'h00, fifo_flush_req});
    $display("test flush done");
    i3c_enabled <= 1'b0;
    wr(slew_regs_pkg::PATH_RESET_OFFSET, 8'h10, 1'b0);
    cmp("soft_reset_pulse", 8'h01, {7'h00, soft_reset_pulse});
    rd(slew_regs_pkg::PATH_RESET_OFFSET);
    cmp("path_reset", 8'h10, rd_val);
    repeat (12) @(posedge clk_sys);
    #1;
    cmp("soft_reset_pulse", 8'h00, {7'h00, soft_reset_pulse});
    slew_q = 8'h2B;
    src_q = 0;
    rd(slew_regs_pkg::SLEW_SELECT_OFFSET);
    cmp("slew_select", 8'h2B, rd_val);
    chk_out();
    link.fire(0);
    chk_out();
    wr(slew_regs_pkg::SLEW_SELECT_OFFSET, 8'h09, 1'b1);
    slew_q = 8'h09;
    src_q = 1;
    repeat (3) @(posedge clk_sys);
    #1;
    chk_out();
    $display("test soft reset and first write done");
    end_sim();
  end
endmodule
